// ==== rtl/smbus_byte_engine.v ====
// Two-wire bus byte engine: data register, bit shifting, mode tracking,
// byte flag and clock stretching. Assumes open-drain pins resolved outside
// and control strobes from logic on clk.
`timescale 1ns/1ps
`include "smbus_consts.vh"

module smbus_byte_engine (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Special-function register port
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata_q,
  // Control from the two-wire control register
  input wire enable,
  input wire slave_enable,
  input wire start_req,
  input wire stop_req,
  input wire ack_out,
  input wire flag_clear,
  // Status
  output reg byte_flag_q,
  output reg irq_q,
  output reg [1:0] mode_q,
  output reg master_q,
  output reg ack_rcvd_q,
  // Clock pin
  input wire scl_in,
  output reg scl_out_q,
  output reg scl_oe_n_q,
  // Data pin
  input wire sda_in,
  output reg sda_out_q,
  output reg sda_oe_n_q
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_DATA = 3'h2;
  localparam [2:0] S_ACKWAIT = 3'h3;
  localparam [2:0] S_ACK = 3'h4;
  localparam [2:0] S_ACKEND = 3'h5;
  localparam [2:0] S_HOLD = 3'h6;
  localparam [2:0] S_STOP = 3'h7;
  localparam [31:0] HALF_CYC = `SCL_HALF_CYC;
  localparam [2:0] HALF = HALF_CYC[2:0];

  function sfr_hit;
    input [7:0] a;
    begin
      sfr_hit = (a == `BYTE_BUF_ADDR);
    end
  endfunction

  reg rst_s1_q, rst_n_q;
  reg scl_s1_q, scl_s_q, scl_p_q;
  reg sda_s1_q, sda_s_q, sda_p_q;
  reg [2:0] state_q;
  reg [2:0] cnt_q;
  reg [2:0] tmr_q;
  reg tx_q, addr_q, pre_ack_q, stop_pend_q;
  reg flag_set;
  reg shift_en;
  wire [7:0] buf_q;

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      scl_s1_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_s1_q <= scl_in;
      scl_s_q <= scl_s1_q;
      scl_p_q <= scl_s_q;
      sda_s1_q <= sda_in;
      sda_s_q <= sda_s1_q;
      sda_p_q <= sda_s_q;
    end
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  // Arbitration is lost when we release data but the wire reads low
  wire arb_lost = master_q & tx_q & sda_oe_n_q & ~sda_s_q;

  // ****************************************
  // Data register
  // ****************************************
  // Writes are taken unless a shift lands in the same cycle; software keeps them to flag-set time
  byte_shift_reg u_buf (
    .clk(clk),
    .rst_n(rst_n_q),
    .load(sfr_wr & sfr_hit(sfr_addr)),
    .load_data(sfr_wdata),
    .shift(shift_en),
    .shift_bit(sda_s_q),
    .q(buf_q)
  );

  always @*
  begin
    // Every sampled bit goes in, sending or not, so the byte matches the wire
    shift_en = (state_q == S_DATA) & scl_rise;
  end

  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      sfr_rdata_q <= 8'h00;
    else if (sfr_rd & sfr_hit(sfr_addr))
      sfr_rdata_q <= buf_q;
    else
      sfr_rdata_q <= 8'h00;
  end

  // ****************************************
  // Byte flag
  // ****************************************
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      byte_flag_q <= 1'b0;
      irq_q <= 1'b0;
      mode_q <= `MODE_SLAVE_RX;
    end
    else
    begin
      // A set in the clearing cycle wins
      byte_flag_q <= flag_set | (byte_flag_q & ~flag_clear);
      irq_q <= flag_set | (byte_flag_q & ~flag_clear);
      mode_q <= {~master_q, ~tx_q};
    end
  end

  // ****************************************
  // Bit engine
  // ****************************************
  always @*
  begin
    flag_set = 1'b0;
    if (state_q == S_ACKWAIT && scl_fall && !tx_q)
      flag_set = 1'b1;
    if (state_q == S_ACKEND && scl_fall && (tx_q || (addr_q && !master_q && buf_q[0])))
      flag_set = 1'b1;
  end

  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= S_IDLE;
      cnt_q <= 3'h0;
      tmr_q <= 3'h0;
      tx_q <= 1'b0;
      addr_q <= 1'b0;
      pre_ack_q <= 1'b0;
      stop_pend_q <= 1'b0;
      master_q <= 1'b0;
      ack_rcvd_q <= 1'b0;
      scl_out_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_out_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end
    else if (!enable)
    begin
      state_q <= S_IDLE;
      master_q <= 1'b0;
      tx_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end
    else
    begin
      // Master clock generator; the wait on a high wire lets slaves stretch
      if (master_q && state_q >= S_DATA && state_q <= S_ACKEND)
      begin
        if (!scl_oe_n_q || scl_s_q)
        begin
          if (tmr_q == HALF - 3'h1)
          begin
            tmr_q <= 3'h0;
            scl_oe_n_q <= ~scl_oe_n_q;
          end
          else
            tmr_q <= tmr_q + 3'h1;
        end
        else
          tmr_q <= 3'h0;
      end
      if (!master_q && bus_stop)
      begin
        state_q <= S_IDLE;
        tx_q <= 1'b0;
        scl_oe_n_q <= 1'b1;
        sda_oe_n_q <= 1'b1;
      end
      else if (!master_q && bus_start && slave_enable)
      begin
        state_q <= S_DATA;
        cnt_q <= 3'h0;
        tx_q <= 1'b0;
        addr_q <= 1'b1;
        sda_oe_n_q <= 1'b1;
      end
      else
      case (state_q)
        S_IDLE:
        begin
          if (start_req && scl_s_q && sda_s_q)
          begin
            sda_oe_n_q <= 1'b0;
            master_q <= 1'b1;
            tx_q <= 1'b1;
            addr_q <= 1'b1;
            tmr_q <= 3'h0;
            state_q <= S_START;
          end
        end
        S_START:
        begin
          if (tmr_q == HALF - 3'h1)
          begin
            scl_oe_n_q <= 1'b0;
            tmr_q <= 3'h0;
            cnt_q <= 3'h0;
            state_q <= S_DATA;
          end
          else
            tmr_q <= tmr_q + 3'h1;
        end
        S_DATA:
        begin
          if (scl_fall && tx_q)
            sda_oe_n_q <= buf_q[7];
          if (scl_rise)
          begin
            cnt_q <= cnt_q + 3'h1;
            if (arb_lost)
            begin
              // Keep shifting as slave receiver; the byte stays correct
              master_q <= 1'b0;
              tx_q <= 1'b0;
              sda_oe_n_q <= 1'b1;
              scl_oe_n_q <= 1'b1;
            end
            if (cnt_q == 3'h7)
              state_q <= S_ACKWAIT;
          end
        end
        S_ACKWAIT:
        begin
          if (scl_fall)
          begin
            if (tx_q)
            begin
              sda_oe_n_q <= 1'b1;
              state_q <= S_ACK;
            end
            else
            begin
              // Stretch so software can pick the acknowledge
              scl_oe_n_q <= 1'b0;
              pre_ack_q <= 1'b1;
              state_q <= S_HOLD;
            end
          end
        end
        S_ACK:
        begin
          if (scl_rise)
          begin
            if (tx_q)
              ack_rcvd_q <= ~sda_s_q;
            state_q <= S_ACKEND;
          end
        end
        S_ACKEND:
        begin
          if (scl_fall)
          begin
            if (tx_q && master_q && addr_q && ack_rcvd_q && buf_q[0])
              tx_q <= 1'b0;
            if (!tx_q && !master_q && addr_q && buf_q[0])
              tx_q <= 1'b1;
            addr_q <= 1'b0;
            if (flag_set)
            begin
              scl_oe_n_q <= 1'b0;
              sda_oe_n_q <= 1'b1;
              pre_ack_q <= 1'b0;
              state_q <= S_HOLD;
            end
            else if (stop_pend_q)
            begin
              stop_pend_q <= 1'b0;
              scl_oe_n_q <= 1'b0;
              sda_oe_n_q <= 1'b0;
              tmr_q <= 3'h0;
              state_q <= S_STOP;
            end
            else
            begin
              sda_oe_n_q <= 1'b1;
              cnt_q <= 3'h0;
              state_q <= S_DATA;
            end
          end
        end
        S_HOLD:
        begin
          // Register is untouched by the engine here
          if (!byte_flag_q)
          begin
            tmr_q <= 3'h0;
            if (pre_ack_q)
            begin
              sda_oe_n_q <= ~ack_out;
              stop_pend_q <= stop_req & master_q;
              scl_oe_n_q <= ~master_q;
              state_q <= S_ACK;
            end
            else if (stop_req && master_q)
            begin
              sda_oe_n_q <= 1'b0;
              state_q <= S_STOP;
            end
            else
            begin
              // Clock already low, so the first bit goes out now
              sda_oe_n_q <= tx_q ? buf_q[7] : 1'b1;
              scl_oe_n_q <= ~master_q;
              cnt_q <= 3'h0;
              state_q <= S_DATA;
            end
          end
        end
        S_STOP:
        begin
          scl_oe_n_q <= 1'b1;
          if (scl_s_q)
          begin
            if (tmr_q == HALF - 3'h1)
            begin
              sda_oe_n_q <= 1'b1;
              master_q <= 1'b0;
              tx_q <= 1'b0;
              state_q <= S_IDLE;
            end
            else
              tmr_q <= tmr_q + 3'h1;
          end
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

endmodule

// ==== rtl/smbus_consts.vh ====
// Constants for the two-wire byte engine: register offset, reset value,
// transfer mode codes and bus timing. Assumes a 10 MHz core clock.
// Overview of operation
// - The data register holds one byte, queued to send or last received.
// - Outgoing bytes are shifted onto the bus most significant bit first.
// - The first received bit ends up in the register's most significant bit.
// - Bus level is shifted in while sending, so the register holds the last byte.
// - Losing arbitration as master transmitter turns into slave receiver, data intact.
// - While the byte flag is set the register stays stable and is freely accessible.
// - The register sits at address C2, resets to zero, and is read-write.
// - Master, slave or both; always exactly one of four transfer modes.
// - Master mode starts with a generated START, ends on lost arbitration or STOP.
// - Every byte frame ends with the byte flag and interrupt request raised.
// - As receiver the byte interrupt comes before the acknowledge bit.
// - As transmitter the byte interrupt comes after the acknowledge is sampled.
`ifndef SMBUS_CONSTS_VH
`define SMBUS_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define BYTE_BUF_ADDR 8'hC2
`define BYTE_BUF_RESET 8'h00

// ****************************************
// Transfer modes, as {slave, receiver}
// ****************************************
`define MODE_MASTER_TX 2'h0
`define MODE_MASTER_RX 2'h1
`define MODE_SLAVE_TX 2'h2
`define MODE_SLAVE_RX 2'h3

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 100
`define SCL_HALF_NS 400
`define SCL_HALF_CYC (`SCL_HALF_NS / `CLK_PERIOD_NS)

`endif

// ==== rtl/byte_shift_reg.v ====
// Byte register with a serial shift path and a parallel load path.
// Assumes the caller never asks for both in the same cycle.
`timescale 1ns/1ps
`include "smbus_consts.vh"

module byte_shift_reg (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Parallel load
  input wire load,
  input wire [7:0] load_data,
  // Serial shift, new bit enters at the bottom
  input wire shift,
  input wire shift_bit,
  // Contents
  output reg [7:0] q
);

  // ****************************************
  // Storage
  // ****************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= `BYTE_BUF_RESET;
    else if (shift)
      // Bit order keeps first sampled bit at the top once 8 are in
      q <= {q[6:0], shift_bit};
    else if (load)
      q <= load_data;
  end

endmodule

// ==== tb/smbus_byte_engine_checker.sv ====
// Concurrent checks on the byte engine top ports.
// Assumes the engine clock and its active-low reset as seen at the top.
`timescale 1ns/1ps
`include "smbus_consts.vh"

module smbus_byte_engine_checker (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire [7:0] sfr_addr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata_q,
  // Control and status
  input wire enable,
  input wire flag_clear,
  input wire byte_flag_q,
  input wire irq_q,
  input wire [1:0] mode_q,
  input wire master_q,
  // Pins
  input wire scl_oe_n_q,
  input wire sda_oe_n_q
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_irq_follows; irq_q == byte_flag_q; endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq differs from flag");
  property p_rd_idle; !(sfr_rd && sfr_addr == `BYTE_BUF_ADDR) |=> sfr_rdata_q == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_stretch; byte_flag_q && $past(byte_flag_q) |-> !scl_oe_n_q; endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held");
  property p_flag_hold; byte_flag_q && enable && !flag_clear |=> byte_flag_q; endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  property p_mode; mode_q[1] == !$past(master_q); endproperty
  a_mode: assert property (p_mode) else $error("mode not tracking master");
  property p_master_start; $rose(master_q) |-> ##[0:4] !sda_oe_n_q; endproperty
  a_master_start: assert property (p_master_start) else $error("master without start");
  property p_pins_off; !enable ##1 !enable |=> scl_oe_n_q && sda_oe_n_q && !master_q; endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins driven while off");
  property p_rx_flag; $rose(byte_flag_q) && mode_q[0] |-> sda_oe_n_q; endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("ack driven before flag");
endmodule

bind smbus_byte_engine smbus_byte_engine_checker u_smbus_byte_engine_checker (.*);

// ==== tb/smbus_bus_partner.sv ====
// Far-side bus party: acking slave, arbitration rival, stand-in clock.
// Assumes open-drain wires with pull-ups; device pins arrive as enables.
`timescale 1ns/1ps

module smbus_bus_partner (
  // Device enables, low drives low
  input wire scl_oe_n,
  input wire sda_oe_n,
  // Behaviour select
  input wire lose_en,
  input wire [3:0] lose_k,
  // Resolved wires
  output wire scl,
  output wire sda
);
  reg p_scl = 1'b1;
  reg p_sda = 1'b1;
  reg [7:0] shift_q = 8'h00;
  reg [7:0] rx_byte = 8'h00;
  reg [3:0] cnt = 4'h0;
  assign scl = scl_oe_n & p_scl;
  assign sda = sda_oe_n & p_sda;
  // A START restarts the bit count
  always @(negedge sda)
    if (scl)
      cnt = 4'h0;
  always @(posedge scl)
  begin
    shift_q = {shift_q[6:0], sda};
    cnt = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
    if (cnt == 4'h8)
      rx_byte = shift_q;
  end
  // Ack as slave, or hold data low from a chosen bit on to win arbitration
  always @(negedge scl)
    p_sda = !(lose_en ? (cnt >= lose_k && cnt < 4'h8) : cnt == 4'h8);
  // Clock of the winning master once the device has dropped out
  task run_clock(input integer n);
    repeat (n)
    begin
      #400 p_scl = 1'b0;
      #400 p_scl = 1'b1;
    end
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the byte engine against a far-side bus party.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`include "smbus_consts.vh"

module tb;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg [7:0] sfr_wdata = 8'h00;
  reg sfr_wr = 1'b0;
  reg sfr_rd = 1'b0;
  reg enable = 1'b0;
  reg slave_enable = 1'b0;
  reg start_req = 1'b0;
  reg stop_req = 1'b0;
  reg ack_out = 1'b1;
  reg flag_clear = 1'b0;
  reg lose_en = 1'b0;
  wire [7:0] sfr_rdata_q;
  wire [1:0] mode_q;
  wire byte_flag_q, irq_q, master_q, ack_rcvd_q, scl_in, sda_in;
  wire scl_out_q, scl_oe_n_q, sda_out_q, sda_oe_n_q;
  integer failures = 0;
  integer cmp_count = 0;
  integer i;
  reg [31:0] seed = 32'h160F9E55;
  reg [7:0] a;
  always #50 clk = ~clk;
  smbus_byte_engine u_smbus_byte_engine (.*);
  smbus_bus_partner u_smbus_bus_partner (.scl_oe_n(scl_oe_n_q), .sda_oe_n(sda_oe_n_q),
    .lose_en(lose_en), .lose_k(4'h3), .scl(scl_in), .sda(sda_in));
  // ****************************************
  // Helpers
  // ****************************************
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Rival holds data low from the fourth bit, so only the top three survive
  function [7:0] lost_byte(input [7:0] x);
    lost_byte = x & 8'hE0;
  endfunction
  task chk(input string nm, input [7:0] e, input [7:0] g);
    cmp_count = cmp_count + 1;
    if (e !== g)
    begin
      failures = failures + 1;
      $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] ad, input [7:0] v);
    @(posedge clk);
    #1 sfr_addr = ad;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask
  task rd(input [7:0] ad, input [7:0] e);
    @(posedge clk);
    #1 sfr_addr = ad;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1 sfr_rd = 1'b0;
    chk("buffer", e, sfr_rdata_q);
  endtask
  task clr;
    @(posedge clk);
    #1 flag_clear = 1'b1;
    @(posedge clk);
    #1 flag_clear = 1'b0;
  endtask
  task st;
    @(posedge clk);
    #1 start_req = 1'b1;
    @(posedge clk);
    #1 start_req = 1'b0;
  endtask
  task wait_flag;
    repeat (2000) if (byte_flag_q !== 1'b1) @(posedge clk) #1;
    chk("flag", 8'h01, {7'h00, byte_flag_q});
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    rd(`BYTE_BUF_ADDR, `BYTE_BUF_RESET);
    for (i = 0; i < 4; i = i + 1)
    begin
      seed = lfsr(seed);
      wr(`BYTE_BUF_ADDR, seed[7:0]);
      wr(8'hC3, ~seed[7:0]);
      rd(`BYTE_BUF_ADDR, seed[7:0]);
      rd(8'hC3, 8'h00);
    end
    seed = lfsr(seed);
    a = {seed[7:1], 1'b0};
    wr(`BYTE_BUF_ADDR, a);
    enable = 1'b1;
    st;
    repeat (8) if (master_q !== 1'b1) @(posedge clk);
    chk("master", 8'h01, {7'h00, master_q});
    wait_flag;
    chk("sent", a, u_smbus_bus_partner.rx_byte);
    chk("clocks", 8'h09, {4'h0, u_smbus_bus_partner.cnt});
    chk("mode", {6'h00, `MODE_MASTER_TX}, {6'h00, mode_q});
    chk("ack", 8'h01, {7'h00, ack_rcvd_q});
    repeat (20) @(posedge clk);
    chk("held", 8'h00, {7'h00, scl_in});
    rd(`BYTE_BUF_ADDR, a);
    wr(`BYTE_BUF_ADDR, 8'h01);
    clr;
    wait_flag;
    chk("sent", 8'h01, u_smbus_bus_partner.rx_byte);
    stop_req = 1'b1;
    clr;
    repeat (100) if (master_q !== 1'b0) @(posedge clk);
    repeat (10) @(posedge clk) #1;
    chk("stop", 8'h03, {6'h00, scl_in, sda_in});
    stop_req = 1'b0;
    // Master read: address acked, all ones from the released wire, then nack and stop
    enable = 1'b0;
    seed = lfsr(seed);
    a = {seed[7:1], 1'b1};
    wr(`BYTE_BUF_ADDR, a);
    enable = 1'b1;
    st;
    wait_flag;
    chk("ack", 8'h01, {7'h00, ack_rcvd_q});
    clr;
    wait_flag;
    chk("clocks", 8'h08, {4'h0, u_smbus_bus_partner.cnt});
    chk("mode", {6'h00, `MODE_MASTER_RX}, {6'h00, mode_q});
    rd(`BYTE_BUF_ADDR, 8'hFF);
    ack_out = 1'b0;
    stop_req = 1'b1;
    clr;
    repeat (300) if (master_q !== 1'b0) @(posedge clk) #1;
    chk("read stop", 8'h00, {7'h00, master_q});
    ack_out = 1'b1;
    stop_req = 1'b0;
    lose_en = 1'b1;
    slave_enable = 1'b1;
    enable = 1'b0;
    seed = lfsr(seed);
    a = seed[7:0] | 8'h10;
    wr(`BYTE_BUF_ADDR, a);
    enable = 1'b1;
    st;
    repeat (8) @(posedge clk);
    repeat (400) if (master_q !== 1'b0) @(posedge clk);
    #1 u_smbus_bus_partner.run_clock(5);
    wait_flag;
    chk("clocks", 8'h08, {4'h0, u_smbus_bus_partner.cnt});
    chk("mode", {6'h00, `MODE_SLAVE_RX}, {6'h00, mode_q});
    rd(`BYTE_BUF_ADDR, lost_byte(a));
    clr;
    #800;
    chk("ack bit", 8'h00, {7'h00, u_smbus_bus_partner.shift_q[0]});
    chk("drive level", 8'h00, {6'h00, scl_out_q, sda_out_q});
    enable = 1'b0;
    repeat (4) @(posedge clk);
    test_done;
  end
  // Whole run is near 60 us; far past that something hangs
  initial
  begin
    #1000000;
    failures = failures + 1;
    test_done;
  end
endmodule
